// ---- design/plam_top.sv ----
// plam_top: executes left/right doubleword and halfword partial loads
// assumes: decode hands one load at a time with base and old target
// values; translation and memory answer by a one-cycle ack each
//
// Operation
// - opcode 011010 decodes as dword left load
// - opcode 011011 decodes as dword right load
// - opcode 100001 decodes as signed half load
// - opcode 100101 decodes as unsigned half load
// - left load fills upper bytes, keeps lower
// - right load fills lower bytes, keeps upper
// - byte choice uses address bits and endianness
// - right merge by same byte index
// - dword loads unaligned; listed exceptions only
// - signed half is sign-extended to register
// - unsigned half is zero-extended to register
// - odd half address faults, no write
// - 32-bit half index from two bits
// - 64-bit half index from three bits
`timescale 1ns/10ps
module plam_top
   import plam_pkg::*;
#(
   parameter int COUNT_W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic issue_valid_i,
   input wire plam_issue_t issue_i,
   output logic issue_ready_o,
   output logic xlat_req_o,
   output logic [XLEN-1:0] virtual_addr_o,
   input wire logic xlat_ack_i,
   input wire plam_xlat_t xlat_i,
   output logic mem_req_o,
   output logic [PADDR_W-1:0] mem_paddr_o,
   input wire logic mem_ack_i,
   input wire logic [XLEN-1:0] mem_data_i,
   input wire logic mem_bus_err_i,
   output logic rf_we_o,
   output logic [4:0] rf_addr_o,
   output logic [XLEN-1:0] rf_data_o,
   output logic exc_valid_o,
   output plam_exc_t exc_code_o
);
   // ==========================================================
   // elaboration check
   // ==========================================================
   if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count
      $error("COUNT_W must lie in 1..32");
   end

   plam_state_t state_q, state_d;
   plam_op_t op_q, op_d, dec_op;
   plam_exc_t exc_code_q, exc_code_d, last_exc_q, last_exc_d;
   plam_ctrl_t ctrl;
   logic [XLEN-1:0] virtual_addr_q, virtual_addr_d, rt_old_q, rt_old_d, ea;
   logic [XLEN-1:0] rf_data_q, rf_data_d, merge_res;
   logic [PADDR_W-1:0] paddr_q, paddr_d, pa_adj;
   logic [4:0] rt_addr_q, rt_addr_d;
   logic [COUNT_W-1:0] count_q, count_d;
   logic [2:0] rev_mask, idx;
   logic ready_q, ready_d, xreq_q, xreq_d, mreq_q, mreq_d;
   logic rf_we_q, rf_we_d, exc_q, exc_d;
   logic is_dword, is_half, take;

   // ==========================================================
   // decode and effective address
   // ==========================================================
   always_comb begin
      case (issue_i.instr[OPC_HI:OPC_LO])
         OPC_DWORD_LEFT: dec_op = OP_DWORD_LEFT;
         OPC_DWORD_RIGHT: dec_op = OP_DWORD_RIGHT;
         OPC_HALF_SIGNED: dec_op = OP_HALF_SIGNED;
         OPC_HALF_UNSIGNED: dec_op = OP_HALF_UNSIGNED;
         default: dec_op = OP_NONE;
      endcase
      // base field selects the register whose value arrives in base_val
      ea = issue_i.base_val
         + {{(XLEN-16){issue_i.instr[OFFS_HI]}}, issue_i.instr[15:0]};
      take = issue_valid_i && ready_q;
   end

   // ==========================================================
   // physical address adjustment of the held operation
   // ==========================================================
   always_comb begin
      is_dword = (op_q == OP_DWORD_LEFT) || (op_q == OP_DWORD_RIGHT);
      is_half = (op_q == OP_HALF_SIGNED) || (op_q == OP_HALF_UNSIGNED);
      if (is_dword) begin
         rev_mask = {3{ctrl.reverse_endian_flag}};
      end else if (ctrl.is64) begin
         rev_mask = {ctrl.reverse_endian_flag, ctrl.reverse_endian_flag, 1'b0};
      end else begin
         rev_mask = {1'b0, ctrl.reverse_endian_flag, 1'b0};
      end
      pa_adj = {xlat_i.paddr[PADDR_W-1:3], xlat_i.paddr[2:0] ^ rev_mask};
      // aligned doubleword requested when memory order wants it
      if ((op_q == OP_DWORD_LEFT && !ctrl.memory_big_endian_flag) ||
          (op_q == OP_DWORD_RIGHT && ctrl.memory_big_endian_flag)) begin
         pa_adj[2:0] = 3'b000;
      end
   end

   // ==========================================================
   // sequencer: issue, translate, memory, write back
   // ==========================================================
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      virtual_addr_d = virtual_addr_q;
      rt_old_d = rt_old_q;
      rt_addr_d = rt_addr_q;
      paddr_d = paddr_q;
      xreq_d = xreq_q;
      mreq_d = mreq_q;
      rf_we_d = 1'b0;
      rf_data_d = rf_data_q;
      exc_d = 1'b0;
      exc_code_d = exc_code_q;
      count_d = count_q;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               op_d = dec_op;
               virtual_addr_d = ea;
               rt_old_d = issue_i.rt_old;
               rt_addr_d = issue_i.instr[TGT_HI:TGT_LO];
               // dword loads exist only in 64-bit mode
               if (dec_op == OP_NONE || (!ctrl.is64 &&
                   (dec_op == OP_DWORD_LEFT || dec_op == OP_DWORD_RIGHT))) begin
                  exc_d = 1'b1;
                  exc_code_d = EXC_RESERVED;
               end else if ((dec_op == OP_HALF_SIGNED ||
                             dec_op == OP_HALF_UNSIGNED) && ea[0]) begin
                  exc_d = 1'b1;
                  exc_code_d = EXC_ADDR_ERROR;
               end else begin
                  // no alignment test on dword loads
                  state_d = ST_XLATE;
                  xreq_d = 1'b1;
               end
            end
         end
         ST_XLATE: begin
            if (xlat_ack_i) begin
               xreq_d = 1'b0;
               if (xlat_i.tlb_refill) begin
                  exc_d = 1'b1;
                  exc_code_d = EXC_TLB_REFILL;
                  state_d = ST_IDLE;
               end else if (xlat_i.tlb_invalid) begin
                  exc_d = 1'b1;
                  exc_code_d = EXC_TLB_INVALID;
                  state_d = ST_IDLE;
               end else begin
                  paddr_d = pa_adj;
                  mreq_d = 1'b1;
                  state_d = ST_MEM;
               end
            end
         end
         ST_MEM: begin
            if (mem_ack_i) begin
               mreq_d = 1'b0;
               state_d = ST_IDLE;
               if (mem_bus_err_i) begin
                  exc_d = 1'b1;
                  exc_code_d = EXC_BUS_ERROR;
               end else begin
                  rf_we_d = 1'b1;
                  rf_data_d = merge_res;
                  count_d = count_q + 1'b1;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
            xreq_d = 1'b0;
            mreq_d = 1'b0;
         end
      endcase
      ready_d = (state_d == ST_IDLE);
      last_exc_d = exc_d ? exc_code_d : last_exc_q;
   end

   // state and output registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         op_q <= OP_NONE;
         virtual_addr_q <= '0;
         rt_old_q <= '0;
         rt_addr_q <= 5'h00;
         paddr_q <= '0;
         xreq_q <= 1'b0;
         mreq_q <= 1'b0;
         rf_we_q <= 1'b0;
         rf_data_q <= '0;
         exc_q <= 1'b0;
         exc_code_q <= EXC_NONE;
         last_exc_q <= EXC_NONE;
         count_q <= COUNT_RST[COUNT_W-1:0];
         ready_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         virtual_addr_q <= virtual_addr_d;
         rt_old_q <= rt_old_d;
         rt_addr_q <= rt_addr_d;
         paddr_q <= paddr_d;
         xreq_q <= xreq_d;
         mreq_q <= mreq_d;
         rf_we_q <= rf_we_d;
         rf_data_q <= rf_data_d;
         exc_q <= exc_d;
         exc_code_q <= exc_code_d;
         last_exc_q <= last_exc_d;
         count_q <= count_d;
         ready_q <= ready_d;
      end
   end

   // ==========================================================
   // merge datapath and register slave
   // ==========================================================
   plam_merge u_merge (
      .op_i(op_q),
      .is64_i(ctrl.is64),
      .cpu_big_i(ctrl.cpu_big_endian_flag),
      .virtual_addr_lo_i(virtual_addr_q[2:0]),
      .mem_i(mem_data_i),
      .rt_i(rt_old_q),
      .idx_o(idx),
      .res_o(merge_res)
   );

   plam_regs u_regs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .busy_i(!ready_q),
      .last_exc_i(last_exc_q),
      .count_i(32'(count_q)),
      .ctrl_o(ctrl)
   );

   // outputs straight from flops
   assign issue_ready_o = ready_q;
   assign xlat_req_o = xreq_q;
   assign virtual_addr_o = virtual_addr_q;
   assign mem_req_o = mreq_q;
   assign mem_paddr_o = paddr_q;
   assign rf_we_o = rf_we_q;
   assign rf_addr_o = rt_addr_q;
   assign rf_data_o = rf_data_q;
   assign exc_valid_o = exc_q;
   assign exc_code_o = exc_code_q;

   // ==========================================================
   // assertions
   // ==========================================================
   a_left_decode: assert property (@(posedge clk_i) disable iff (rst_i)
      take && issue_i.instr[31:26] == 6'h1a |=> op_q == OP_DWORD_LEFT)
      else $error("left load opcode not decoded");
   a_right_decode: assert property (@(posedge clk_i) disable iff (rst_i)
      take && issue_i.instr[31:26] == 6'h1b |=> op_q == OP_DWORD_RIGHT)
      else $error("right load opcode not decoded");
   a_half_decode: assert property (@(posedge clk_i) disable iff (rst_i)
      take && (issue_i.instr[31:26] == 6'h21 || issue_i.instr[31:26] == 6'h25)
      |=> (op_q == OP_HALF_SIGNED) == ($past(issue_i.instr[28]) == 1'b0))
      else $error("half load opcode not decoded");
   a_ea_sum: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(xlat_req_o) |-> virtual_addr_o == $past(issue_i.base_val)
         + {{48{$past(issue_i.instr[15])}}, $past(issue_i.instr[15:0])})
      else $error("effective address wrong");
   a_half_odd: assert property (@(posedge clk_i) disable iff (rst_i)
      take && (dec_op == OP_HALF_SIGNED || dec_op == OP_HALF_UNSIGNED) && ea[0]
      |=> exc_valid_o && exc_code_o == EXC_ADDR_ERROR && !xlat_req_o
          ##1 !rf_we_o)
      else $error("odd half address not faulted");
   a_tlb_precise: assert property (@(posedge clk_i) disable iff (rst_i)
      state_q == ST_XLATE && xlat_ack_i &&
      (xlat_i.tlb_refill || xlat_i.tlb_invalid)
      |=> exc_valid_o && !mem_req_o && !rf_we_o ##1 !mem_req_o && !rf_we_o)
      else $error("tlb fault not precise");
   a_left_align: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(mem_req_o) && op_q == OP_DWORD_LEFT &&
      !ctrl.memory_big_endian_flag |-> mem_paddr_o[2:0] == 3'b000)
      else $error("left load address not aligned");
   a_right_align: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(mem_req_o) && op_q == OP_DWORD_RIGHT &&
      ctrl.memory_big_endian_flag |-> mem_paddr_o[2:0] == 3'b000)
      else $error("right load address not aligned");
   a_sign_ext: assert property (@(posedge clk_i) disable iff (rst_i)
      rf_we_o && op_q == OP_HALF_SIGNED |-> rf_data_o[63:16] == {48{rf_data_o[15]}})
      else $error("signed half not sign-extended");
   a_zero_ext: assert property (@(posedge clk_i) disable iff (rst_i)
      rf_we_o && op_q == OP_HALF_UNSIGNED |-> rf_data_o[63:16] == 48'h0000_0000_0000)
      else $error("unsigned half not zero-extended");
   a_left_merge: assert property (@(posedge clk_i) disable iff (rst_i)
      rf_we_o && op_q == OP_DWORD_LEFT && idx == 3'h0 |->
      rf_data_o == {$past(mem_data_i[7:0]), rt_old_q[55:0]})
      else $error("left merge wrong");
   a_right_merge: assert property (@(posedge clk_i) disable iff (rst_i)
      rf_we_o && op_q == OP_DWORD_RIGHT && idx == 3'h0 |->
      rf_data_o == $past(mem_data_i))
      else $error("right merge wrong");
   a_reserved_op: assert property (@(posedge clk_i) disable iff (rst_i)
      take && dec_op == OP_NONE |=> exc_valid_o && exc_code_o == EXC_RESERVED)
      else $error("unknown opcode not reserved");

   c_left_load: cover property (@(posedge clk_i) disable iff (rst_i)
      rf_we_o && op_q == OP_DWORD_LEFT);
   c_right_load: cover property (@(posedge clk_i) disable iff (rst_i)
      rf_we_o && op_q == OP_DWORD_RIGHT);
   c_half_fault: cover property (@(posedge clk_i) disable iff (rst_i)
      exc_valid_o && exc_code_o == EXC_ADDR_ERROR);
   c_tlb_fault: cover property (@(posedge clk_i) disable iff (rst_i)
      exc_valid_o && exc_code_o == EXC_TLB_REFILL);

endmodule // plam_top

// ---- shared/plam_pkg.sv ----
// plam_pkg: constants, encodings and carriers of the load align/merge unit
// assumes: one 100 MHz core clock, 64-bit general registers
package plam_pkg;

   // ==========================================================
   // instruction fields and primary opcodes
   // ==========================================================
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 26;
   localparam int BASE_HI = 25;
   localparam int BASE_LO = 21;
   localparam int TGT_HI = 20;
   localparam int TGT_LO = 16;
   localparam int OFFS_HI = 15;
   localparam logic [5:0] OPC_DWORD_LEFT = 6'h1a;
   localparam logic [5:0] OPC_DWORD_RIGHT = 6'h1b;
   localparam logic [5:0] OPC_HALF_SIGNED = 6'h21;
   localparam logic [5:0] OPC_HALF_UNSIGNED = 6'h25;

   // ==========================================================
   // widths
   // ==========================================================
   localparam int XLEN = 64;
   localparam int PADDR_W = 36;

   // ==========================================================
   // register map, fields, reset values
   // ==========================================================
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_COUNT = 8'h08;
   localparam int CTRL_MEM_BIG = 0;
   localparam int CTRL_CPU_BIG = 1;
   localparam int CTRL_REVERSE = 2;
   localparam int CTRL_IS64 = 3;
   localparam int STAT_EXC_LO = 0;
   localparam int STAT_BUSY = 4;
   localparam logic [3:0] CTRL_RST = 4'hb;
   localparam logic [31:0] COUNT_RST = 32'h0000_0000;

   // ==========================================================
   // enumerations
   // ==========================================================
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_DWORD_LEFT = 3'b001,
      OP_DWORD_RIGHT = 3'b010,
      OP_HALF_SIGNED = 3'b011,
      OP_HALF_UNSIGNED = 3'b100
   } plam_op_t;

   typedef enum logic [2:0] {
      EXC_NONE = 3'b000,
      EXC_TLB_REFILL = 3'b001,
      EXC_TLB_INVALID = 3'b010,
      EXC_BUS_ERROR = 3'b011,
      EXC_ADDR_ERROR = 3'b100,
      EXC_RESERVED = 3'b101
   } plam_exc_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XLATE = 2'b01,
      ST_MEM = 2'b10
   } plam_state_t;

   // ==========================================================
   // carriers
   // ==========================================================
   typedef struct packed {
      logic [31:0] instr;
      logic [XLEN-1:0] base_val;
      logic [XLEN-1:0] rt_old;
   } plam_issue_t;

   typedef struct packed {
      logic [PADDR_W-1:0] paddr;
      logic tlb_refill;
      logic tlb_invalid;
   } plam_xlat_t;

   typedef struct packed {
      logic is64;
      logic reverse_endian_flag;
      logic cpu_big_endian_flag;
      logic memory_big_endian_flag;
   } plam_ctrl_t;

endpackage

// ---- design/plam_merge.sv ----
// plam_merge: byte index and result merge for the four partial loads
// assumes: purely combinational, fed from registered operands
`timescale 1ns/10ps
module plam_merge
   import plam_pkg::*;
(
   input wire plam_op_t op_i,
   input wire logic is64_i,
   input wire logic cpu_big_i,
   input wire logic [2:0] virtual_addr_lo_i,
   input wire logic [XLEN-1:0] mem_i,
   input wire logic [XLEN-1:0] rt_i,
   output logic [2:0] idx_o,
   output logic [XLEN-1:0] res_o
);
   localparam logic [XLEN-1:0] ONES = {XLEN{1'b1}};

   logic [2:0] idx;
   logic [XLEN-1:0] src;
   logic [XLEN-1:0] shifted;
   logic [XLEN-1:0] lmask;
   logic [XLEN-1:0] rmask;
   logic [15:0] half;

   // ==========================================================
   // byte index, source word and masks
   // ==========================================================
   always_comb begin
      src = mem_i;
      if (op_i == OP_DWORD_LEFT || op_i == OP_DWORD_RIGHT) begin
         idx = virtual_addr_lo_i ^ {3{cpu_big_i}};
      end else if (is64_i) begin
         idx = virtual_addr_lo_i ^ {cpu_big_i, cpu_big_i, 1'b0};
      end else begin
         // word-wide memory: upper half of the bus is ignored
         idx = {1'b0, virtual_addr_lo_i[1:0] ^ {cpu_big_i, 1'b0}};
         src = {32'h0000_0000, mem_i[31:0]};
      end
      // the lmask shift count is 7 bits so that a full 64-bit shift clears
      lmask = ONES >> ({1'b0, idx, 3'b000} + 7'h08);
      rmask = ~(ONES >> {idx, 3'b000});
      shifted = src >> {idx, 3'b000};
      half = shifted[15:0];
   end

   // ==========================================================
   // result selection
   // ==========================================================
   always_comb begin
      case (op_i)
         OP_DWORD_LEFT: begin
            // memory low bytes on top, old low part kept
            res_o = (src << (6'h38 - {idx, 3'b000})) | (rt_i & lmask);
         end
         OP_DWORD_RIGHT: begin
            res_o = shifted | (rt_i & rmask);
         end
         OP_HALF_SIGNED: begin
            res_o = {{(XLEN-16){half[15]}}, half};
         end
         OP_HALF_UNSIGNED: begin
            res_o = {{(XLEN-16){1'b0}}, half};
         end
         default: begin
            res_o = rt_i;
         end
      endcase
      idx_o = idx;
   end

endmodule // plam_merge

// ---- design/plam_regs.sv ----
// plam_regs: classic wishbone slave holding control, showing status
// assumes: single-cycle requests held until ack, 32-bit data
`timescale 1ns/10ps
module plam_regs
   import plam_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic busy_i,
   input wire plam_exc_t last_exc_i,
   input wire logic [31:0] count_i,
   output plam_ctrl_t ctrl_o
);
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   plam_ctrl_t ctrl_q, ctrl_d;
   logic take;

   // ==========================================================
   // decode: ack one cycle after the strobe, dropped next cycle
   // ==========================================================
   always_comb begin
      take = wb_cyc_i && wb_stb_i && !ack_q;
      ack_d = take;
      ctrl_d = ctrl_q;
      dat_d = 32'h0000_0000;
      if (take && wb_we_i) begin
         // only lane 0 carries control bits
         if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            ctrl_d = plam_ctrl_t'(wb_dat_i[3:0]);
         end
      end else if (take) begin
         if (wb_adr_i == REG_CTRL) begin
            dat_d = {28'h000_0000, ctrl_q};
         end else if (wb_adr_i == REG_STATUS) begin
            dat_d = {27'h000_0000, busy_i, 1'b0, last_exc_i};
         end else if (wb_adr_i == REG_COUNT) begin
            dat_d = count_i;
         end else begin
            dat_d = 32'h0000_0000; // unmapped reads zero
         end
      end
   end

   // registered answers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         ctrl_q <= plam_ctrl_t'(CTRL_RST);
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign ctrl_o = ctrl_q;

endmodule // plam_regs

// ---- tb/plam_mem_model.sv ----
// plam_mem_model: translation and memory side of the load unit
// assumes: request levels held until the answering ack edge
`timescale 1ns/10ps
module plam_mem_model
   import plam_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic xreq_i,
   input wire logic [XLEN-1:0] virtual_addr_i,
   input wire logic mreq_i,
   input wire logic [2:0] flt_i,
   input wire logic [1:0] slow_i,
   input wire logic [XLEN-1:0] data_i,
   output logic xack_o,
   output plam_xlat_t xlat_o,
   output logic mack_o,
   output logic [XLEN-1:0] mdat_o,
   output logic berr_o
);
   logic [1:0] wait_q;
   // =========================================
   // answer after slow_i cycles; idle lines toggle so stale data shows
   always @(posedge clk_i) begin
      xack_o <= 1'b0;
      mack_o <= 1'b0;
      xlat_o <= rst_i ? '0 : ~xlat_o;
      mdat_o <= rst_i ? '0 : ~mdat_o;
      berr_o <= rst_i ? 1'b0 : ~berr_o;
      if (rst_i || !(xreq_i || mreq_i) || xack_o || mack_o) wait_q <= 2'h0;
      else if (wait_q != slow_i) wait_q <= wait_q + 2'h1;
      else if (xreq_i) begin
         xack_o <= 1'b1;
         xlat_o <= {virtual_addr_i[PADDR_W-1:0], flt_i[0], flt_i[1]};
      end else begin
         mack_o <= 1'b1;
         mdat_o <= data_i;
         berr_o <= flt_i[2];
      end
   end
endmodule // plam_mem_model

// ---- tb/testbench.sv ----
// testbench: random partial loads against a behavioural model
// assumes: plam_top with wishbone control and plam_mem_model far side
`timescale 1ns/10ps
module testbench
   import plam_pkg::*;
;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic issue_valid_i = 0, wb_ack_o, issue_ready_o, xlat_req_o, xlat_ack_i;
   logic mem_req_o, mem_ack_i, mem_bus_err_i, rf_we_o, exc_valid_o;
   logic [7:0] wb_adr_i = 0;
   logic [3:0] wb_sel_i = 4'hf, ctl = 4'hb;
   logic [31:0] wb_dat_i = 0, wb_dat_o, q, seed = 32'h0000_0739;
   plam_issue_t issue_i = '0;
   plam_xlat_t xlat_i;
   plam_exc_t exc_code_o;
   logic [XLEN-1:0] virtual_addr_o, mem_data_i, rf_data_o, memd = 0, last = 0;
   logic [PADDR_W-1:0] mem_paddr_o;
   logic [4:0] rf_addr_o;
   logic [2:0] flt = 0, last_e = 0;
   logic [1:0] slow = 0;
   logic [5:0] ops [5] = '{6'h1a, 6'h1b, 6'h21, 6'h25, 6'h3f};
   int err_count = 0, num_checks = 0, cyc_n = 0, cnt = 0, k;
   plam_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .issue_valid_i, .issue_i,
      .issue_ready_o, .xlat_req_o, .virtual_addr_o, .xlat_ack_i, .xlat_i, .mem_req_o,
      .mem_paddr_o, .mem_ack_i, .mem_data_i, .mem_bus_err_i, .rf_we_o,
      .rf_addr_o, .rf_data_o, .exc_valid_o, .exc_code_o);
   plam_mem_model mem_u (.clk_i, .rst_i, .xreq_i(xlat_req_o),
      .virtual_addr_i(virtual_addr_o), .mreq_i(mem_req_o), .flt_i(flt), .slow_i(slow),
      .data_i(memd), .xack_o(xlat_ack_i), .xlat_o(xlat_i),
      .mack_o(mem_ack_i), .mdat_o(mem_data_i), .berr_o(mem_bus_err_i));
   // =========================================
   // clock and hang guard
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) if (++cyc_n == 20000) begin
      err_count++;
      tally_and_finish;
   end
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
      return seed;
   endfunction
   task chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // classic cycle held until ack is sampled at a rising edge
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task ld(input logic [5:0] opc, input logic [2:0] f);
      logic [63:0] b, m, r, ea;
      logic [15:0] off;
      logic [35:0] p, pa;
      logic [2:0] e, pm;
      logic hf;
      int i;
      b = {rnd(), rnd()};
      m = {rnd(), rnd()};
      off = 16'(rnd());
      hf = opc[5];
      if (hf) off[0] = 1'b0;
      ea = b + {{48{off[15]}}, off};
      e = (opc == 6'h3f || (!hf && !ctl[3])) ? 3'h5 : (hf & ea[0]) ? 3'h4
         : f[0] ? 3'h1 : f[1] ? 3'h2 : f[2] ? 3'h3 : 3'h0;
      i = !hf ? ea[2:0] ^ {3{ctl[1]}} : ctl[3] ? ea[2:0] ^ {ctl[1], ctl[1], 1'b0}
         : {1'b0, ea[1:0] ^ {ctl[1], 1'b0}};
      pm = !hf ? {3{ctl[2]}} : {ctl[3] & ctl[2], ctl[2], 1'b0};
      p = ea[35:0] ^ pm;
      if (opc[0] == ctl[0] && !hf) p[2:0] = 3'h0;
      r = m >> 8 * i;
      if (opc == 6'h1a) r = (m << (56 - 8 * i)) | (last & ((64'h1 << (56 - 8 * i)) - 1));
      if (opc == 6'h1b) r = r | (last & ~({64{1'b1}} >> 8 * i));
      if (hf) r = {{48{r[15] & ~opc[2]}}, r[15:0]};
      @(posedge clk_i);
      issue_valid_i <= 1'b1;
      memd <= m;
      flt <= f;
      slow <= 2'(rnd());
      // base and target fields are 10 bits together
      issue_i <= {opc, 10'(rnd()), off, b, last};
      do @(posedge clk_i); while (issue_ready_o !== 1'b1);
      issue_valid_i <= 1'b0;
      do begin
         @(posedge clk_i);
         if (mem_req_o === 1'b1) pa = mem_paddr_o;
      end while (rf_we_o !== 1'b1 && exc_valid_o !== 1'b1);
      if (e == 3'h0 || e == 3'h3) chk(pa, p);
      chk(exc_valid_o, e != 3'h0);
      chk(rf_we_o, e == 3'h0);
      if (e != 3'h0) chk(exc_code_o, e);
      else begin
         chk(rf_data_o, r);
         chk(rf_addr_o, issue_i.instr[20:16]);
         last = r;
         cnt++;
      end
      if (e != 3'h0) last_e = e;
   endtask
   task tally_and_finish;
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // =========================================
   // main sequence: control mixes, loads, status and count
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_CTRL, 0);
      chk(q, CTRL_RST);
      wb(1'b0, 8'h0c, 0);
      chk(q, 0);
      for (k = 0; k < 300; k++) begin
         if (k % 8 == 0) begin
            ctl = 4'(rnd());
            wb(1'b1, REG_CTRL, ctl);
            wb(1'b0, REG_CTRL, 0);
            chk(q, ctl);
         end
         ld(ops[rnd() % 5], seed[9] ? (3'h1 << seed[6:5]) : 3'h0);
         wb(1'b0, REG_STATUS, 0);
         // busy bit must read low once the load has finished
         chk(q[4:0], {2'b00, last_e});
      end
      wb(1'b0, REG_COUNT, 0);
      chk(q, cnt);
      tally_and_finish;
   end
endmodule // testbench
